/* File: logic/mtc_tx.sv */
// coded serial transmitter: registers, prescaler, baud divider, shifter, status
`timescale 1ns/1ps
// Behaviour
// [RULE_01] baud divisor codes 0..4 give period 4, higher codes their own value
// [RULE_02] baud counter output divided by two gives bit rate base/(2k)
// [RULE_03] software clears enable before changing the baud divisor
// [RULE_04] status is read-only, writes ignored, only top bit nonzero
// [RULE_05] status reads zero after reset and while enable is clear
// [RULE_06] busy flag high while sending, low when done with nothing queued
// [RULE_07] busy flag stays high without gap in continuous transmission
// [RULE_08] software waits for busy low before restarting a transmission
// [RULE_09] stop mode sends nothing and hands the pin back to the port
// [RULE_10] mode bit 7 is the unit enable
// [RULE_11] mode bit 4 picks first bit: 0 msb, 1 lsb
// [RULE_12] mode bit 1 picks format: 0 manchester, 1 plain bits
// [RULE_13] mode bit 0 sets the idle line level
// [RULE_14] software clears enable before changing mode bits, except in one write
// [RULE_15] base clock select divides by 1..32; codes 6 and 7 prohibited
// [RULE_16] reset values: mode 10h, base 00h, baud 1Fh, status 00h
// [RULE_17] writing the buffer while enabled starts a transmission
// [RULE_18] bit count field sends count plus one bits, resets to eight
// [RULE_19] each manchester bit is two half periods with a mid-bit edge
module mtc_tx #(
   parameter int FIFO_DEPTH = 8
) (
   input wire logic sys_clk, // peripheral clock, 50 MHz
   input wire logic rstn, // asynchronous reset, active low
   input wire logic [15:0] addr, // register address
   input wire logic wr_en, // write strobe
   input wire logic rd_en, // read strobe
   input wire logic [7:0] wdata, // write data
   output logic [7:0] rdata, // read data, one cycle after rd_en
   output logic tx_buf_ready, // buffer can take a byte
   output logic coded_out_pin, // serial output level
   output logic coded_out_en, // pin owned by this unit
   output logic tx_start_irq // pulse when a byte enters the shifter
);
   typedef enum logic {MTC_IDLE, MTC_SHIFT} mtc_state_e;

   mtc_state_e state, next_state;
   logic [7:0] mode_control, base_clock_select, baud_divisor, tx_bit_count, tx_buffer;
   logic [7:0] next_mode, next_base, next_baud, next_bitcnt, next_txbuf, next_rdata;
   logic [4:0] pre_cnt, next_pre_cnt, pre_lim, baud_cnt, next_baud_cnt, k_val;
   logic [7:0] shreg, next_shreg;
   logic [3:0] bits_left, next_bits_left;
   logic half, next_half, next_out, next_irq;
   logic unit_enable, first_bit_select, format_select, idle_level;
   logic base_tick, half_tick, last_half, cur_bit, tx_in_progress, load;
   logic fifo_wr, fifo_valid;
   logic [10:0] fifo_data;
   logic [7:0] pop_byte;
   logic [2:0] pop_cnt;

   initial begin
      if (FIFO_DEPTH < 2) begin
         $error("buffer depth must be at least 2");
      end
   end

   // ************************************************************
   // register file
   // ************************************************************

   assign unit_enable = mode_control[mtc_pkg::BIT_ENABLE]; // RULE_10
   assign first_bit_select = mode_control[mtc_pkg::BIT_FIRST];
   assign format_select = mode_control[mtc_pkg::BIT_FORMAT];
   assign idle_level = mode_control[mtc_pkg::BIT_IDLE];

   // register writes and read mux; status address takes no write
   always_comb begin
      next_mode = mode_control;
      next_base = base_clock_select;
      next_baud = baud_divisor;
      next_bitcnt = tx_bit_count;
      next_txbuf = tx_buffer;
      next_rdata = rdata;
      fifo_wr = 1'b0;
      if (wr_en) begin
         if (addr == mtc_pkg::ADDR_MODE) begin
            next_mode = wdata & mtc_pkg::MASK_MODE; // RULE_14
         end else if (addr == mtc_pkg::ADDR_BASECLK) begin
            next_base = wdata & mtc_pkg::MASK_BASECLK;
         end else if (addr == mtc_pkg::ADDR_BAUD) begin
            next_baud = wdata & mtc_pkg::MASK_BAUD; // RULE_03
         end else if (addr == mtc_pkg::ADDR_BITCNT) begin
            next_bitcnt = wdata & mtc_pkg::MASK_BITCNT;
         end else if (addr == mtc_pkg::ADDR_TXBUF) begin
            next_txbuf = wdata;
            fifo_wr = unit_enable; // RULE_17
         end
      end
      if (rd_en) begin
         if (addr == mtc_pkg::ADDR_MODE) begin
            next_rdata = mode_control;
         end else if (addr == mtc_pkg::ADDR_BASECLK) begin
            next_rdata = base_clock_select;
         end else if (addr == mtc_pkg::ADDR_BAUD) begin
            next_rdata = baud_divisor;
         end else if (addr == mtc_pkg::ADDR_BITCNT) begin
            next_rdata = tx_bit_count;
         end else if (addr == mtc_pkg::ADDR_TXBUF) begin
            next_rdata = tx_buffer;
         end else if (addr == mtc_pkg::ADDR_STATUS) begin
            next_rdata = {tx_in_progress && unit_enable, 7'h00}; // RULE_04 RULE_05
         end else begin
            next_rdata = 8'h00;
         end
      end
   end

   // register file flops
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         mode_control <= mtc_pkg::RST_MODE; // RULE_16
         base_clock_select <= mtc_pkg::RST_BASECLK;
         baud_divisor <= mtc_pkg::RST_BAUD;
         tx_bit_count <= mtc_pkg::RST_BITCNT; // RULE_18
         tx_buffer <= mtc_pkg::RST_TXBUF;
         rdata <= mtc_pkg::RST_STATUS;
      end else begin
         mode_control <= next_mode;
         base_clock_select <= next_base;
         baud_divisor <= next_baud;
         tx_bit_count <= next_bitcnt;
         tx_buffer <= next_txbuf;
         rdata <= next_rdata;
      end
   end

   // ************************************************************
   // transmit buffer: byte and its bit count travel together
   // ************************************************************
   mtc_fifo #(
      .WIDTH(11),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .flush(!unit_enable),
      .in_valid(fifo_wr),
      .in_ready(tx_buf_ready),
      .in_data({tx_bit_count[2:0], wdata}),
      .out_valid(fifo_valid),
      .out_ready(load),
      .out_data(fifo_data)
   );
   assign pop_byte = fifo_data[7:0];
   assign pop_cnt = fifo_data[10:8];

   // ************************************************************
   // prescaler and baud divider
   // ************************************************************

   // base clock tick every 2^code cycles, none for prohibited codes
   always_comb begin
      pre_lim = 5'((6'h01 << base_clock_select[2:0]) - 6'h01); // RULE_15
      base_tick = (state == MTC_SHIFT) && (pre_cnt == pre_lim)
         && (base_clock_select[2:0] <= mtc_pkg::CKS_MAX);
      k_val = (baud_divisor[4:0] < mtc_pkg::K_MIN) ? mtc_pkg::K_MIN : baud_divisor[4:0]; // RULE_01
      half_tick = base_tick && (baud_cnt == k_val - 5'h01);
      next_pre_cnt = (state != MTC_SHIFT || base_tick) ? 5'h00 : pre_cnt + 5'h01;
      next_baud_cnt = baud_cnt;
      if (state != MTC_SHIFT || half_tick) begin
         next_baud_cnt = 5'h00;
      end else if (base_tick) begin
         next_baud_cnt = baud_cnt + 5'h01;
      end
   end

   // ************************************************************
   // shifter and output
   // ************************************************************

   // bit under transmission and end of the last half period
   always_comb begin
      cur_bit = first_bit_select ? shreg[0] : shreg[7]; // RULE_11
      last_half = (state == MTC_SHIFT) && half_tick && half && (bits_left == 4'h1);
      load = unit_enable && fifo_valid && (state == MTC_IDLE || last_half); // RULE_07
      tx_in_progress = (state == MTC_SHIFT) || fifo_valid; // RULE_06
   end

   // two half periods per bit; next byte loads in the same cycle the last ends
   always_comb begin
      next_state = state;
      next_shreg = shreg;
      next_bits_left = bits_left;
      next_half = half;
      next_irq = 1'b0;
      if (!unit_enable) begin
         next_state = MTC_IDLE; // RULE_09
         next_half = 1'b0;
         next_bits_left = 4'h0;
      end else if (load) begin
         next_state = MTC_SHIFT;
         next_half = 1'b0;
         next_bits_left = {1'b0, pop_cnt} + 4'h1; // RULE_18
         next_shreg = first_bit_select ? pop_byte : (pop_byte << (3'h7 - pop_cnt));
         next_irq = 1'b1;
      end else if (last_half) begin
         next_state = MTC_IDLE;
         next_half = 1'b0;
         next_bits_left = 4'h0;
      end else if (state == MTC_SHIFT && half_tick) begin
         next_half = !half; // RULE_02
         if (half) begin
            next_bits_left = bits_left - 4'h1;
            next_shreg = first_bit_select ? (shreg >> 1) : (shreg << 1);
         end
      end
   end

   // line level: idle level, plain bit, or inverted then true half
   always_comb begin
      if (state != MTC_SHIFT) begin
         next_out = idle_level; // RULE_13
      end else if (format_select) begin
         next_out = cur_bit; // RULE_12
      end else begin
         next_out = half ? cur_bit : !cur_bit; // RULE_19
      end
   end

   // shifter and pin flops
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         state <= MTC_IDLE;
         pre_cnt <= 5'h00;
         baud_cnt <= 5'h00;
         shreg <= 8'h00;
         bits_left <= 4'h0;
         half <= 1'b0;
         coded_out_pin <= 1'b0;
         coded_out_en <= 1'b0;
         tx_start_irq <= 1'b0;
      end else begin
         state <= next_state;
         pre_cnt <= next_pre_cnt;
         baud_cnt <= next_baud_cnt;
         shreg <= next_shreg;
         bits_left <= next_bits_left;
         half <= next_half;
         coded_out_pin <= next_out;
         coded_out_en <= unit_enable; // RULE_09
         tx_start_irq <= next_irq;
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   sequence s_status_read;
      rd_en && addr == mtc_pkg::ADDR_STATUS;
   endsequence

   sequence s_reload_due;
      last_half && fifo_valid && unit_enable;
   endsequence

   chk_k_floor_four: assert property (baud_divisor[4:0] < 5'h04 |-> k_val == 5'h04) // RULE_01
      else $error("baud period below four");
   chk_half_toggle: assert property (state == MTC_SHIFT && half_tick && !half
      && unit_enable |=> half) // RULE_02
      else $error("half period did not advance");
   chk_status_low_bits: assert property (s_status_read |=> rdata[6:0] == 7'h00) // RULE_04
      else $error("status low bits not zero");
   chk_status_stop_zero: assert property (s_status_read ##0 !unit_enable |=> rdata == 8'h00) // RULE_05
      else $error("status nonzero while stopped");
   chk_busy_no_gap: assert property (s_reload_due
      |=> state == MTC_SHIFT && !half && tx_in_progress) // RULE_07
      else $error("busy gap between words");
   chk_stop_releases: assert property (!unit_enable |=> state == MTC_IDLE && !coded_out_en) // RULE_09
      else $error("stop mode still driving");
   chk_idle_line: assert property (state == MTC_IDLE && $stable(mode_control)
      |=> coded_out_pin == $past(idle_level)) // RULE_13
      else $error("idle level wrong");
   chk_lsb_first: assert property (load && first_bit_select |=> cur_bit == $past(pop_byte[0])) // RULE_11
      else $error("first bit wrong");
   chk_prohibited_base: assert property (base_clock_select[2:0] > 3'h5 |-> !base_tick) // RULE_15
      else $error("prohibited base clock ticked");
endmodule : mtc_tx

/* File: logic/mtc_pkg.sv */
// constants of the coded serial transmitter: map, fields, reset values, timing
package mtc_pkg;
   // ************************************************************
   // register addresses on the 16-bit memory port
   // ************************************************************
   localparam logic [15:0] ADDR_STATUS = 16'hFF47;
   localparam logic [15:0] ADDR_TXBUF = 16'hFF4A;
   localparam logic [15:0] ADDR_BITCNT = 16'hFF4B;
   localparam logic [15:0] ADDR_MODE = 16'hFF4C;
   localparam logic [15:0] ADDR_BASECLK = 16'hFF4D;
   localparam logic [15:0] ADDR_BAUD = 16'hFF4E;
   // ************************************************************
   // field positions and write masks
   // ************************************************************
   localparam int BIT_ENABLE = 7;
   localparam int BIT_FIRST = 4;
   localparam int BIT_FORMAT = 1;
   localparam int BIT_IDLE = 0;
   localparam int BIT_BUSY = 7;
   localparam logic [7:0] MASK_MODE = 8'h93;
   localparam logic [7:0] MASK_BASECLK = 8'h07;
   localparam logic [7:0] MASK_BAUD = 8'h1F;
   localparam logic [7:0] MASK_BITCNT = 8'h07;
   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic [7:0] RST_MODE = 8'h10;
   localparam logic [7:0] RST_BASECLK = 8'h00;
   localparam logic [7:0] RST_BAUD = 8'h1F;
   localparam logic [7:0] RST_BITCNT = 8'h07;
   localparam logic [7:0] RST_STATUS = 8'h00;
   localparam logic [7:0] RST_TXBUF = 8'hFF;
   // ************************************************************
   // divider limits
   // ************************************************************
   localparam logic [4:0] K_MIN = 5'h04;
   localparam logic [2:0] CKS_MAX = 3'h5;
endpackage : mtc_pkg

/* File: logic/mtc_fifo.sv */
// small first-in first-out buffer with valid and ready on both sides
`timescale 1ns/1ps
module mtc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic sys_clk, // system clock
   input wire logic rstn, // asynchronous reset, active low
   input wire logic flush, // drop all entries
   input wire logic in_valid, // write request
   output logic in_ready, // room for a word
   input wire logic [WIDTH-1:0] in_data, // word written
   output logic out_valid, // word available
   input wire logic out_ready, // word taken
   output logic [WIDTH-1:0] out_data // oldest word
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [AW:0] count, next_count;
   logic push, pop;

   // ************************************************************
   // structure check
   // ************************************************************
   initial begin
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
         $error("fifo depth must be a power of two of at least 2");
      end
   end

   // pointer and fill arithmetic
   always_comb begin
      in_ready = (count != (AW+1)'(DEPTH));
      out_valid = (count != '0);
      out_data = mem[rd_ptr];
      push = in_valid && in_ready && !flush;
      pop = out_valid && out_ready && !flush;
      next_wr_ptr = flush ? '0 : wr_ptr + AW'(push);
      next_rd_ptr = flush ? '0 : rd_ptr + AW'(pop);
      next_count = flush ? '0 : count + (AW+1)'(push) - (AW+1)'(pop);
   end

   // pointer registers
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
      end
   end

   // storage, written without reset
   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end
endmodule : mtc_fifo

/* File: tb/mtc_rx_model.sv */
// receiving end model: samples the coded line and rebuilds each word
`timescale 1ns/1ps
module mtc_rx_model (
   input wire logic sys_clk, // system clock
   input wire logic line, // coded serial line
   input wire logic line_en, // line owned by the sender
   input wire logic start, // pulse as a word enters the sender
   input wire logic [10:0] half, // half bit period in clocks
   input wire logic [3:0] nbits, // bits per word
   input wire logic lsb_first, // low bit goes first
   input wire logic manch, // manchester when high, plain when low
   output int rx_count, // words received whole
   output int n_bad, // bits whose two halves break the format
   output logic [7:0] rx_log [0:31] // received words in order
);
   logic a;
   logic b;
   logic bit_v;
   logic lost;
   logic [7:0] w;
   // ************************************************************
   // one word per start pulse, sampled mid half; a dropped owner aborts it
   // ************************************************************
   initial begin
      rx_count = 0;
      n_bad = 0;
   end
   always begin
      @(posedge sys_clk);
      if (start === 1'b1) begin
         w = 8'h00;
         lost = 1'b0;
         for (int j = 0; j < int'(nbits); j++) begin
            repeat (half / 2) @(posedge sys_clk);
            a = line;
            lost = lost | !line_en;
            repeat (half) @(posedge sys_clk);
            b = line;
            lost = lost | !line_en;
            if (manch ? (a === b) : (a !== b)) n_bad++;
            bit_v = b;
            if (lsb_first) w[j] = bit_v;
            else w[int'(nbits) - 1 - j] = bit_v;
            if (j < int'(nbits) - 1) repeat (half - half / 2) @(posedge sys_clk);
         end
         if (!lost) begin
            rx_log[rx_count % 32] = w;
            rx_count++;
         end
      end
   end
endmodule : mtc_rx_model

/* File: tb/mtc_tx_test.sv */
// self-checking bench of the coded serial transmitter
`timescale 1ns/1ps
module mtc_tx_test;
   typedef struct {logic [7:0] mode, base, baud, cnt, data;} mtc_row_s;
   logic sys_clk, rstn, wr_en, rd_en, lsb, manch;
   logic [15:0] addr;
   logic [7:0] wdata, rdata, v;
   logic tx_buf_ready, coded_out_pin, coded_out_en, tx_start_irq;
   logic [10:0] half;
   logic [3:0] nbits;
   int rx_count, n_bad, n_fail, checks_done, cyc, c0;
   logic [7:0] rx_log [0:31];
   mtc_row_s rows [6] = '{
      '{8'h80, 8'h00, 8'h00, 8'h07, 8'hA5}, '{8'h91, 8'h01, 8'h05, 8'h02, 8'h6E},
      '{8'h82, 8'h02, 8'h04, 8'h07, 8'h3C}, '{8'h93, 8'h03, 8'h07, 8'h04, 8'h5A},
      '{8'h80, 8'h04, 8'h03, 8'h00, 8'h01}, '{8'h82, 8'h05, 8'h1F, 8'h01, 8'h02}};
   logic [15:0] ra [6] = '{mtc_pkg::ADDR_MODE, mtc_pkg::ADDR_BASECLK, mtc_pkg::ADDR_BAUD,
      mtc_pkg::ADDR_BITCNT, mtc_pkg::ADDR_STATUS, 16'hFF40};
   logic [7:0] rst_v [6] = '{8'h10, 8'h00, 8'h1F, 8'h07, 8'h00, 8'h00};
   logic [7:0] msk_v [6] = '{8'h13, 8'h07, 8'h1F, 8'h07, 8'h00, 8'h00};
   mtc_tx #(.FIFO_DEPTH(8)) dut (.sys_clk(sys_clk), .rstn(rstn), .addr(addr), .wr_en(wr_en),
      .rd_en(rd_en), .wdata(wdata), .rdata(rdata), .tx_buf_ready(tx_buf_ready),
      .coded_out_pin(coded_out_pin), .coded_out_en(coded_out_en), .tx_start_irq(tx_start_irq));
   mtc_rx_model rx (.sys_clk(sys_clk), .line(coded_out_pin), .line_en(coded_out_en),
      .start(tx_start_irq), .half(half), .nbits(nbits), .lsb_first(lsb), .manch(manch),
      .rx_count(rx_count), .n_bad(n_bad), .rx_log(rx_log));
   // ************************************************************
   // clock, hang guard and bus tasks
   // ************************************************************
   always #10 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 30000) begin
         n_fail++;
         $display("MISMATCH %0t run hung", $time);
         stop_test();
      end
   end
   task automatic stop_test();
      if (n_fail == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : stop_test
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string m);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %0t %s got %h want %h", $time, m, got, exp);
      end
   endtask : cmp
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge sys_clk);
      wr_en <= 1'b0;
      @(posedge sys_clk);
   endtask : wr
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge sys_clk);
      rd_en <= 1'b0;
      #1;
      d = rdata;
      @(posedge sys_clk);
   endtask : rd
   // program with enable clear, start one word, check word, busy and idle level
   task automatic run_row(input mtc_row_s r);
      c0 = rx_count;
      half = 11'((1 << r.base) * ((r.baud < 8'h05) ? 4 : int'(r.baud)));
      nbits = 4'(r.cnt) + 4'h1;
      lsb = r.mode[4];
      manch = !r.mode[1];
      wr(mtc_pkg::ADDR_MODE, r.mode & 8'h7F);
      wr(mtc_pkg::ADDR_BASECLK, r.base);
      wr(mtc_pkg::ADDR_BAUD, r.baud);
      wr(mtc_pkg::ADDR_BITCNT, r.cnt);
      wr(mtc_pkg::ADDR_MODE, r.mode);
      wr(mtc_pkg::ADDR_TXBUF, r.data);
      rd(mtc_pkg::ADDR_STATUS, v);
      cmp(v, 8'h80, "busy");
      while (rx_count == c0) @(posedge sys_clk);
      cmp(rx_log[c0 % 32], r.data & (8'hFF >> (7 - r.cnt)), "word");
      while (v !== 8'h00) rd(mtc_pkg::ADDR_STATUS, v);
      cmp({7'h00, coded_out_pin}, {7'h00, r.mode[0]}, "idle level");
      cmp(8'(n_bad), 8'h00, "format");
   endtask : run_row
   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      sys_clk = 0; rstn = 0; wr_en = 0; rd_en = 0; addr = 0; wdata = 0;
      half = 4; nbits = 8; lsb = 0; manch = 1; n_fail = 0; checks_done = 0; cyc = 0;
      repeat (3) @(posedge sys_clk);
      rstn <= 1'b1;
      @(posedge sys_clk);
      foreach (rows[i]) run_row(rows[i]);
      // second reset in mid run, then reset values and write masks
      rstn <= 1'b0;
      repeat (3) @(posedge sys_clk);
      rstn <= 1'b1;
      @(posedge sys_clk);
      foreach (ra[i]) begin
         rd(ra[i], v);
         cmp(v, rst_v[i], "reset value");
      end
      foreach (ra[i]) wr(ra[i], (i == 0) ? 8'h7F : 8'hFF);
      foreach (ra[i]) begin
         rd(ra[i], v);
         cmp(v, msk_v[i], "write mask");
      end
      // buffer write while stopped is dropped
      c0 = rx_count;
      wr(mtc_pkg::ADDR_TXBUF, 8'h55);
      repeat (200) @(posedge sys_clk);
      cmp(8'(rx_count - c0), 8'h00, "stopped send");
      cmp({7'h00, coded_out_en}, 8'h00, "pin owner");
      // fill buffer until refused, then continuous send
      wr(mtc_pkg::ADDR_BASECLK, 8'h00);
      wr(mtc_pkg::ADDR_BAUD, 8'h04);
      wr(mtc_pkg::ADDR_MODE, 8'h82);
      half = 4; nbits = 8; lsb = 0; manch = 0;
      c0 = rx_count;
      for (int i = 0; i < 9; i++) wr(mtc_pkg::ADDR_TXBUF, 8'h20 + 8'(i));
      cmp({7'h00, tx_buf_ready}, 8'h00, "buffer full");
      wr(mtc_pkg::ADDR_TXBUF, 8'hEE);
      while (rx_count < c0 + 9) begin
         rd(mtc_pkg::ADDR_STATUS, v);
         cmp(v, 8'h80, "busy gap");
      end
      repeat (100) @(posedge sys_clk);
      cmp(8'(rx_count - c0), 8'h09, "word count");
      for (int i = 0; i < 9; i++) cmp(rx_log[(c0 + i) % 32], 8'h20 + 8'(i), "queued");
      cmp({7'h00, tx_buf_ready}, 8'h01, "buffer empty");
      rd(mtc_pkg::ADDR_STATUS, v);
      cmp(v, 8'h00, "done");
      // abort in mid word by clearing enable
      wr(mtc_pkg::ADDR_MODE, 8'h00);
      wr(mtc_pkg::ADDR_BASECLK, 8'h05);
      wr(mtc_pkg::ADDR_BAUD, 8'h1F);
      wr(mtc_pkg::ADDR_MODE, 8'h80);
      half = 992; manch = 1; c0 = rx_count;
      wr(mtc_pkg::ADDR_TXBUF, 8'h5A);
      repeat (100) @(posedge sys_clk);
      wr(mtc_pkg::ADDR_MODE, 8'h00);
      rd(mtc_pkg::ADDR_STATUS, v);
      cmp(v, 8'h00, "status off");
      cmp({7'h00, coded_out_en}, 8'h00, "pin released");
      repeat (2000) @(posedge sys_clk);
      cmp(8'(rx_count - c0), 8'h00, "aborted word");
      stop_test();
   end
endmodule : mtc_tx_test
